// [common/apm_pkg.sv]
// constants, types and the sleep-duration table of the power-mode controller
package apm_pkg;
  // timing, in the unit as printed and as derived cycle counts
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLEEP_UNIT_NS = 500000;
  localparam int WUP1_NS = 1800000;
  localparam int WUP2_NS = 1200000;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;
  localparam int WUP1_CYC = (WUP1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WUP2_CYC = (WUP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h09;
  localparam logic [5:0] IDX_MODE = 6'h11;
  localparam logic [5:0] IDX_LPCFG = 6'h12;
  localparam logic [5:0] IDX_CMD = 6'h14;
  localparam logic [5:0] IDX_IRQCFG = 6'h20;
  localparam logic [5:0] IDX_FIFO0 = 6'h30;
  localparam logic [5:0] IDX_IFCFG = 6'h34;
  localparam logic [5:0] IDX_FIFO1 = 6'h3e;
  localparam logic [5:0] IDX_FDATA = 6'h3f;

  // field positions
  localparam int MODE_SUSP_BIT = 7;
  localparam int MODE_LPEN_BIT = 6;
  localparam int MODE_DEEP_BIT = 5;
  localparam int MODE_DUR_LSB = 1;
  localparam int LPCFG_VAR_BIT = 6;
  localparam int LPCFG_TMR_BIT = 5;
  localparam int STATUS_SETTLED_BIT = 6;

  // reset values and command code
  localparam logic [3:0] RST_DUR = 4'h0;
  localparam logic [7:0] RST_FIFO = 8'h00;
  localparam logic [3:0] RST_IRQCFG = 4'h0;
  localparam logic [2:0] RST_IFCFG = 3'h0;
  localparam logic [7:0] CMD_SOFTRESET = 8'h5a;

  typedef enum logic [5:0] {
    APM_NORMAL = 6'h01,
    APM_DEEP = 6'h02,
    APM_SUSP = 6'h04,
    APM_STBY = 6'h08,
    APM_LPWAKE = 6'h10,
    APM_LPSLEEP = 6'h20
  } apm_mode_t;

  typedef struct packed {
    logic analog_on;
    logic acq_run;
    logic intf_only;
    logic sample_valid;
    logic fifo_store;
  } apm_pwr_t;

  typedef struct packed {
    logic second_irq_pin_open_drain;
    logic second_irq_pin_polarity;
    logic first_irq_pin_open_drain;
    logic first_irq_pin_polarity;
    logic wdt_en;
    logic wdt_sel;
    logic three_wire_serial_select;
  } apm_pincfg_t;

  typedef struct packed {
    apm_mode_t mode;
    logic lp_variant;
    logic equidistant_timing;
    logic [3:0] sleep_dur;
    apm_pincfg_t pincfg;
    logic [7:0] fifo0;
    logic [7:0] fifo1;
    logic [31:0] cnt;
    logic settled;
    logic stored;
    apm_pwr_t pwr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apm_state_t;

  // sleep length in half-millisecond units
  function automatic logic [11:0] apm_dur_mult(input logic [3:0] c);
    logic [11:0] m;
    m = 12'h001;
    case (c)
      4'h6: m = 12'h002;
      4'h7: m = 12'h004;
      4'h8: m = 12'h008;
      4'h9: m = 12'h00c;
      4'ha: m = 12'h014;
      4'hb: m = 12'h032;
      4'hc: m = 12'h064;
      4'hd: m = 12'h0c8;
      4'he: m = 12'h3e8;
      4'hf: m = 12'h7d0;
      default: m = 12'h001;
    endcase
    return m;
  endfunction
endpackage

// [core/apm_ctrl.sv]
// power-mode controller with apb register slave
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module apm_ctrl #(
  parameter int SLEEP_UNIT_CYC = apm_pkg::SLEEP_UNIT_CYC,
  parameter int WUP1_CYC = apm_pkg::WUP1_CYC,
  parameter int WUP2_CYC = apm_pkg::WUP2_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // from acquisition and interrupt engines
  input wire logic samples_done,
  input wire logic wake_hold,
  input wire logic [7:0] fifo_rd_data,
  // power control and pin settings
  output apm_pkg::apm_pwr_t pwr,
  output apm_pkg::apm_pincfg_t pincfg,
  output apm_pkg::apm_mode_t mode
);

  if (SLEEP_UNIT_CYC < 1 || WUP1_CYC < 1 || WUP2_CYC < 1) begin : g_chk
    $error("cycle counts must be at least one");
  end
  if (SLEEP_UNIT_CYC > 2147483 || WUP1_CYC < WUP2_CYC) begin : g_chk2
    $error("sleep unit too large or settle times swapped");
  end

  apm_pkg::apm_state_t s_q;
  apm_pkg::apm_state_t s_d;

  logic [5:0] idx;
  logic setup;
  logic acc;
  logic mapped;
  logic ok;
  logic nd;
  logic nl;
  logic ns;
  logic [31:0] sleep_cyc;
  logic [31:0] settle_cyc;

  assign idx = paddr[7:2];
  assign setup = psel && !penable && !s_q.pready;
  assign acc = psel && penable && s_q.pready;
  assign nd = pwdata[apm_pkg::MODE_DEEP_BIT];
  assign nl = pwdata[apm_pkg::MODE_LPEN_BIT];
  assign ns = pwdata[apm_pkg::MODE_SUSP_BIT];
  assign sleep_cyc = 32'(apm_pkg::apm_dur_mult(s_q.sleep_dur)
                     * SLEEP_UNIT_CYC);
  assign settle_cyc = s_q.lp_variant ? 32'(WUP2_CYC) : 32'(WUP1_CYC);

  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (idx == apm_pkg::IDX_STATUS || idx == apm_pkg::IDX_MODE) begin
      mapped = 1'b1;
    end else if (idx == apm_pkg::IDX_LPCFG || idx == apm_pkg::IDX_CMD) begin
      mapped = 1'b1;
    end else if (idx == apm_pkg::IDX_IRQCFG || idx == apm_pkg::IDX_IFCFG) begin
      mapped = 1'b1;
    end else if (idx == apm_pkg::IDX_FIFO0 || idx == apm_pkg::IDX_FIFO1) begin
      mapped = 1'b1;
    end else if (idx == apm_pkg::IDX_FDATA) begin
      mapped = 1'b1;
    end
  end

  // access permission per power mode
  always_comb begin
    logic fifo_reg;
    logic susp_lim;
    fifo_reg = idx == apm_pkg::IDX_FIFO0 || idx == apm_pkg::IDX_FIFO1
               || idx == apm_pkg::IDX_FDATA;
    susp_lim = s_q.mode == apm_pkg::APM_SUSP
               || (s_q.mode == apm_pkg::APM_LPSLEEP && !s_q.lp_variant);
    ok = mapped;
    if (!mapped) begin
      ok = 1'b0;
    end else if (idx == apm_pkg::IDX_CMD || idx == apm_pkg::IDX_STATUS) begin
      ok = 1'b1;
    end else if (s_q.mode == apm_pkg::APM_DEEP) begin
      ok = idx == apm_pkg::IDX_MODE || idx == apm_pkg::IDX_IFCFG
           || idx == apm_pkg::IDX_IRQCFG;
    end else if (susp_lim) begin
      ok = !fifo_reg;
    end else if (s_q.mode == apm_pkg::APM_LPWAKE && !s_q.lp_variant) begin
      ok = !(idx == apm_pkg::IDX_FDATA && !pwrite);
    end
  end

  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    s_d = s_q;
    s_d.pready = setup;
    s_d.pwr.fifo_store = 1'b0;
    // read data and error answer are prepared in the setup cycle
    if (setup) begin
      if (idx == apm_pkg::IDX_STATUS) begin
        rd = {1'b0, s_q.settled, s_q.mode};
      end else if (idx == apm_pkg::IDX_MODE) begin
        rd = {s_q.mode == apm_pkg::APM_SUSP || s_q.mode == apm_pkg::APM_STBY,
              s_q.mode == apm_pkg::APM_LPWAKE
              || s_q.mode == apm_pkg::APM_LPSLEEP,
              s_q.mode == apm_pkg::APM_DEEP, s_q.sleep_dur, 1'b0};
      end else if (idx == apm_pkg::IDX_LPCFG) begin
        rd = {1'b0, s_q.lp_variant, s_q.equidistant_timing, 5'h00};
      end else if (idx == apm_pkg::IDX_IRQCFG) begin
        rd = {4'h0, s_q.pincfg[6:3]};
      end else if (idx == apm_pkg::IDX_IFCFG) begin
        rd = {5'h00, s_q.pincfg.wdt_en, s_q.pincfg.wdt_sel,
              s_q.pincfg.three_wire_serial_select};
      end else if (idx == apm_pkg::IDX_FIFO0) begin
        rd = s_q.fifo0;
      end else if (idx == apm_pkg::IDX_FIFO1) begin
        rd = s_q.fifo1;
      end else if (idx == apm_pkg::IDX_FDATA) begin
        rd = fifo_rd_data;
      end
      s_d.pslverr = !ok;
      s_d.prdata = (ok && !pwrite) ? {24'h000000, rd} : 32'h00000000;
    end else if (!psel) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h00000000;
    end

    // power-mode sequencing of the low-power phases
    case (s_q.mode)
      apm_pkg::APM_LPWAKE: begin
        if (!s_q.settled) begin
          if (s_q.cnt <= 32'h00000001) begin
            s_d.settled = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - 32'h00000001;
          end
        end else if (s_q.equidistant_timing && !s_q.stored) begin
          s_d.stored = 1'b1;
          s_d.pwr.fifo_store = 1'b1;
        end else if (!wake_hold && !psel
                     && (s_q.equidistant_timing || samples_done)) begin
          s_d.mode = apm_pkg::APM_LPSLEEP;
          s_d.cnt = sleep_cyc;
        end
      end
      apm_pkg::APM_LPSLEEP: begin
        if (s_q.cnt <= 32'h00000001) begin
          s_d.mode = apm_pkg::APM_LPWAKE;
          s_d.cnt = settle_cyc;
          s_d.settled = 1'b0;
          s_d.stored = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 32'h00000001;
        end
      end
      default: begin
        s_d.cnt = 32'h00000000;
      end
    endcase

    // register writes take effect at the access edge
    if (acc && pwrite && ok) begin
      if (idx == apm_pkg::IDX_MODE) begin
        s_d.sleep_dur = pwdata[apm_pkg::MODE_DUR_LSB +: 4];
        case (s_q.mode)
          apm_pkg::APM_NORMAL: begin
            if (nd && !ns && !nl) begin
              s_d.mode = apm_pkg::APM_DEEP;
              s_d.lp_variant = 1'b0;
              s_d.equidistant_timing = 1'b0;
              s_d.sleep_dur = apm_pkg::RST_DUR;
              s_d.fifo0 = apm_pkg::RST_FIFO;
              s_d.fifo1 = apm_pkg::RST_FIFO;
            end else if (ns && !nd && !nl) begin
              s_d.mode = s_q.lp_variant ? apm_pkg::APM_STBY
                         : apm_pkg::APM_SUSP;
            end else if (nl && !nd && !ns) begin
              s_d.mode = apm_pkg::APM_LPWAKE;
              s_d.cnt = settle_cyc;
              s_d.settled = 1'b0;
              s_d.stored = 1'b0;
            end
          end
          default: begin
            // only all-clear leaves a saving mode; mixes are ignored
            if (!nd && !ns && !nl) begin
              s_d.mode = apm_pkg::APM_NORMAL;
            end
          end
        endcase
      end else if (idx == apm_pkg::IDX_LPCFG) begin
        s_d.lp_variant = pwdata[apm_pkg::LPCFG_VAR_BIT];
        s_d.equidistant_timing = pwdata[apm_pkg::LPCFG_TMR_BIT];
      end else if (idx == apm_pkg::IDX_IRQCFG) begin
        s_d.pincfg[6:3] = pwdata[3:0];
      end else if (idx == apm_pkg::IDX_IFCFG) begin
        s_d.pincfg[2:0] = {pwdata[2], pwdata[1], pwdata[0]};
      end else if (idx == apm_pkg::IDX_FIFO0) begin
        s_d.fifo0 = pwdata[7:0];
      end else if (idx == apm_pkg::IDX_FIFO1) begin
        s_d.fifo1 = pwdata[7:0];
      end else if (idx == apm_pkg::IDX_CMD
                   && pwdata[7:0] == apm_pkg::CMD_SOFTRESET) begin
        // soft reset restores power-on values except the settled and stored flags
        s_d.mode = apm_pkg::APM_NORMAL;
        s_d.lp_variant = 1'b0;
        s_d.equidistant_timing = 1'b0;
        s_d.sleep_dur = apm_pkg::RST_DUR;
        s_d.pincfg = {apm_pkg::RST_IRQCFG, apm_pkg::RST_IFCFG};
        s_d.fifo0 = apm_pkg::RST_FIFO;
        s_d.fifo1 = apm_pkg::RST_FIFO;
        s_d.cnt = 32'h00000000;
      end
    end

    // power outputs follow the next mode so they stay flop-driven
    s_d.pwr.analog_on = s_d.mode == apm_pkg::APM_NORMAL
                        || s_d.mode == apm_pkg::APM_LPWAKE;
    s_d.pwr.intf_only = s_d.mode == apm_pkg::APM_DEEP;
    s_d.pwr.sample_valid = s_d.mode == apm_pkg::APM_NORMAL
                           || (s_d.mode == apm_pkg::APM_LPWAKE
                               && s_d.settled);
    s_d.pwr.acq_run = s_d.pwr.sample_valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.mode <= apm_pkg::APM_NORMAL;
      s_q.lp_variant <= 1'b0;
      s_q.equidistant_timing <= 1'b0;
      s_q.sleep_dur <= apm_pkg::RST_DUR;
      s_q.pincfg <= {apm_pkg::RST_IRQCFG, apm_pkg::RST_IFCFG};
      s_q.fifo0 <= apm_pkg::RST_FIFO;
      s_q.fifo1 <= apm_pkg::RST_FIFO;
      s_q.cnt <= 32'h00000000;
      s_q.settled <= 1'b0;
      s_q.stored <= 1'b0;
      s_q.pwr <= 5'b11010;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pwr = s_q.pwr;
  assign pincfg = s_q.pincfg;
  assign mode = s_q.mode;

  logic wr_mode;
  assign wr_mode = acc && pwrite && idx == apm_pkg::IDX_MODE
                   && paddr[1:0] == 2'b00;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DEEP_ENTRY: assert property (
    wr_mode && s_q.mode == apm_pkg::APM_NORMAL && nd && !ns && !nl
    |=> s_q.mode == apm_pkg::APM_DEEP && pwr.intf_only && !pwr.analog_on)
    else $error("deep suspend not entered");
  AST_DEEP_ONLY_INTF: assert property (
    s_q.mode == apm_pkg::APM_DEEP |-> !pwr.analog_on && !pwr.acq_run
    && s_q.fifo0 == 8'h00 && s_q.lp_variant == 1'b0)
    else $error("deep suspend not interface-only");
  AST_DEEP_PIN_CFG: assert property (
    s_q.mode == apm_pkg::APM_DEEP && acc && pwrite
    && idx == apm_pkg::IDX_IRQCFG && paddr[1:0] == 2'b00
    |=> pincfg[6:3] == $past(pwdata[3:0]))
    else $error("pin setting lost in deep suspend");
  AST_SOFTRESET: assert property (
    acc && pwrite && idx == apm_pkg::IDX_CMD && paddr[1:0] == 2'b00
    && pwdata[7:0] == apm_pkg::CMD_SOFTRESET
    |=> s_q.mode == apm_pkg::APM_NORMAL ##1 pwr.analog_on)
    else $error("soft reset did not return to normal");
  AST_SUSP_FIFO_REFUSED: assert property (
    setup && s_q.mode == apm_pkg::APM_SUSP && paddr == 8'hfc
    |=> pready && pslverr && prdata == 32'h00000000)
    else $error("buffer data reachable in suspend");
  AST_VARIANT_ENTRY: assert property (
    wr_mode && s_q.mode == apm_pkg::APM_NORMAL && ns && !nd && !nl
    |=> s_q.mode == (s_q.lp_variant ? apm_pkg::APM_STBY
                     : apm_pkg::APM_SUSP) && !pwr.analog_on)
    else $error("suspend or standby entry wrong");
  AST_SLEEP_UNPOWERED: assert property (
    s_q.mode == apm_pkg::APM_LPSLEEP |-> !pwr.analog_on && !pwr.sample_valid)
    else $error("analog powered in sleep phase");
  AST_SETTLE_FIRST: assert property (
    $rose(s_q.mode == apm_pkg::APM_LPWAKE) |-> !pwr.sample_valid [*3])
    else $error("samples valid before settling");
  AST_EDT_HOLD: assert property (
    s_q.mode == apm_pkg::APM_LPWAKE && wake_hold
    |=> s_q.mode != apm_pkg::APM_LPSLEEP)
    else $error("slept while interrupt holds wake");
  AST_UNDEF_IGNORED: assert property (
    wr_mode && s_q.mode == apm_pkg::APM_NORMAL && nd && ns
    |=> $stable(s_q.mode))
    else $error("undefined mode bits changed mode");
  AST_SLEEP_LENGTH: assert property (
    $rose(s_q.mode == apm_pkg::APM_LPSLEEP)
    |-> s_q.cnt == $past(sleep_cyc))
    else $error("sleep length wrong");
  AST_NORMAL_POWERED: assert property (
    s_q.mode == apm_pkg::APM_NORMAL |-> pwr.analog_on && pwr.acq_run
    && !pwr.intf_only && pwr.sample_valid)
    else $error("normal mode not fully powered");
  AST_SUSP_RETAIN: assert property (
    s_q.mode == apm_pkg::APM_SUSP
    |=> $stable(s_q.fifo0) || s_q.mode == apm_pkg::APM_NORMAL)
    else $error("setup lost in suspend");
  AST_STBY_FREE: assert property (
    setup && s_q.mode == apm_pkg::APM_STBY && paddr == 8'hfc
    |=> pready && !pslverr)
    else $error("standby refused an access");
  AST_LP1_FDATA: assert property (
    setup && !pwrite && s_q.mode == apm_pkg::APM_LPWAKE && !s_q.lp_variant
    && paddr == 8'hfc |=> pready && pslverr)
    else $error("buffer data read in first low-power variant");
  AST_EDT_SLEEP: assert property (
    s_q.mode == apm_pkg::APM_LPWAKE && pwr.sample_valid && samples_done
    && !s_q.equidistant_timing && !wake_hold && !psel
    |=> s_q.mode == apm_pkg::APM_LPSLEEP)
    else $error("event-driven wake did not end");
  AST_EST_STORE: assert property (
    $rose(pwr.sample_valid) && s_q.mode == apm_pkg::APM_LPWAKE
    && s_q.equidistant_timing |=> pwr.fifo_store)
    else $error("equidistant sample not stored");
  AST_WAKE_AFTER_SLEEP: assert property (
    s_q.mode == apm_pkg::APM_LPSLEEP && s_q.cnt == 32'h00000001 && !psel
    |=> s_q.mode == apm_pkg::APM_LPWAKE && !pwr.sample_valid)
    else $error("sleep phase did not end in a wake phase");

  COV_DEEP: cover property (s_q.mode == apm_pkg::APM_DEEP);
  COV_STBY: cover property (s_q.mode == apm_pkg::APM_STBY);
  COV_LP_CYCLE: cover property (
    s_q.mode == apm_pkg::APM_LPSLEEP ##1 s_q.mode == apm_pkg::APM_LPWAKE);
  COV_EST_STORE: cover property (pwr.fifo_store);
  COV_LP2_SLEEP: cover property (
    s_q.mode == apm_pkg::APM_LPSLEEP && s_q.lp_variant);
endmodule

// [dv/apm_host.sv]
// apb host model driving the register slave of the power-mode controller
`timescale 1ns/1ps
module apm_host (
  // clock
  input wire logic pclk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // entered just after a rising edge; returns one idle cycle later
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no limit here: the bench watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines flip so a stale value is never trusted
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    // idle gap after every transfer keeps suspend write spacing
    @(posedge pclk);
  endtask
endmodule

// [dv/test_accel_power_mode_control.sv]
// self-checking bench of the power-mode controller
`timescale 1ns/1ps
module test_accel_power_mode_control;
  localparam int UNIT = 4;
  localparam int W1 = 6;
  localparam int W2 = 3;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic samples_done, wake_hold;
  logic [7:0] fifo_rd_data;
  apm_pkg::apm_pwr_t pwr;
  apm_pkg::apm_pincfg_t pincfg;
  apm_pkg::apm_mode_t mode;
  int n_errors, checks;
  int mult[16] = '{1, 1, 1, 1, 1, 1, 2, 4, 8, 12, 20, 50, 100, 200,
                   1000, 2000};

  apm_ctrl #(.SLEEP_UNIT_CYC(UNIT), .WUP1_CYC(W1), .WUP2_CYC(W2))
    u_apm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .samples_done(samples_done), .wake_hold(wake_hold),
    .fifo_rd_data(fifo_rd_data), .pwr(pwr), .pincfg(pincfg), .mode(mode));
  apm_host u_apm_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  always #2 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr_chk(input logic [5:0] i, input logic [7:0] d,
                        input logic xe);
    logic [31:0] r;
    logic e;
    u_apm_host.xfer(1'b1, i, d, r, e);
    chk({31'h0, e}, {31'h0, xe}, "write error flag");
  endtask
  task automatic rd_chk(input logic [5:0] i, input logic [31:0] xd,
                        input logic xe);
    logic [31:0] r;
    logic e;
    u_apm_host.xfer(1'b0, i, 8'h00, r, e);
    chk(r, xd, "read data");
    chk({31'h0, e}, {31'h0, xe}, "read error flag");
  endtask
  task automatic mode_chk(input apm_pkg::apm_mode_t xm);
    @(negedge pclk);
    chk({26'h0, mode}, {26'h0, xm}, "power mode");
    @(posedge pclk);
  endtask

  task automatic t_reset();
    @(negedge pclk);
    chk({26'h0, mode}, {26'h0, apm_pkg::APM_NORMAL}, "reset mode");
    chk({27'h0, pwr}, {27'h0, 5'b11010}, "reset power");
    chk({25'h0, pincfg}, 32'h0000_0000, "reset pins");
    @(posedge pclk);
    rd_chk(6'h3b, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_entry();
    logic [7:0] lpv[3] = '{8'h00, 8'h00, 8'h40};
    logic [7:0] mb[3] = '{8'h20, 8'h80, 8'h80};
    apm_pkg::apm_mode_t xm[3] = '{apm_pkg::APM_DEEP, apm_pkg::APM_SUSP,
                                 apm_pkg::APM_STBY};
    for (int k = 0; k < 3; k++) begin
      wr_chk(apm_pkg::IDX_LPCFG, lpv[k], 1'b0);
      wr_chk(apm_pkg::IDX_MODE, mb[k], 1'b0);
      @(negedge pclk);
      chk({26'h0, mode}, {26'h0, xm[k]}, "entered");
      chk({31'h0, pwr.analog_on}, 32'h0, "analog off");
      @(posedge pclk);
      wr_chk(apm_pkg::IDX_CMD, apm_pkg::CMD_SOFTRESET, 1'b0);
      mode_chk(apm_pkg::APM_NORMAL);
    end
  endtask
  task automatic t_deep();
    wr_chk(apm_pkg::IDX_IRQCFG, 8'h0a, 1'b0);
    wr_chk(apm_pkg::IDX_IFCFG, 8'h05, 1'b0);
    wr_chk(apm_pkg::IDX_LPCFG, 8'h40, 1'b0);
    wr_chk(apm_pkg::IDX_FIFO0, 8'h33, 1'b0);
    wr_chk(apm_pkg::IDX_MODE, 8'ha0, 1'b0);
    mode_chk(apm_pkg::APM_NORMAL);
    wr_chk(apm_pkg::IDX_MODE, 8'h20, 1'b0);
    @(negedge pclk);
    chk({30'h0, pwr.intf_only, pwr.acq_run}, 32'h2, "deep power");
    chk({25'h0, pincfg}, 32'h55, "pins kept");
    @(posedge pclk);
    rd_chk(apm_pkg::IDX_IRQCFG, 32'h0a, 1'b0);
    rd_chk(apm_pkg::IDX_FIFO0, 32'h00, 1'b1);
    wr_chk(apm_pkg::IDX_MODE, 8'h00, 1'b0);
    mode_chk(apm_pkg::APM_NORMAL);
    rd_chk(apm_pkg::IDX_LPCFG, 32'h00, 1'b0);
    rd_chk(apm_pkg::IDX_FIFO0, 32'h00, 1'b0);
  endtask
  task automatic t_susp();
    // settings lost in deep suspend are written again
    wr_chk(apm_pkg::IDX_LPCFG, 8'h00, 1'b0);
    wr_chk(apm_pkg::IDX_FIFO0, 8'h33, 1'b0);
    wr_chk(apm_pkg::IDX_MODE, 8'h80, 1'b0);
    mode_chk(apm_pkg::APM_SUSP);
    rd_chk(apm_pkg::IDX_MODE, 32'h80, 1'b0);
    rd_chk(apm_pkg::IDX_FIFO1, 32'h00, 1'b1);
    rd_chk(apm_pkg::IDX_FDATA, 32'h00, 1'b1);
    wr_chk(apm_pkg::IDX_FIFO0, 8'h44, 1'b1);
    rd_chk(apm_pkg::IDX_LPCFG, 32'h00, 1'b0);
    wr_chk(apm_pkg::IDX_MODE, 8'h40, 1'b0);
    mode_chk(apm_pkg::APM_SUSP);
    wr_chk(apm_pkg::IDX_MODE, 8'h00, 1'b0);
    mode_chk(apm_pkg::APM_NORMAL);
    rd_chk(apm_pkg::IDX_FIFO0, 32'h33, 1'b0);
    wr_chk(apm_pkg::IDX_LPCFG, 8'h40, 1'b0);
    wr_chk(apm_pkg::IDX_MODE, 8'h80, 1'b0);
    mode_chk(apm_pkg::APM_STBY);
    rd_chk(apm_pkg::IDX_FDATA, {24'h0, fifo_rd_data}, 1'b0);
    wr_chk(apm_pkg::IDX_FIFO0, 8'h21, 1'b0);
    wr_chk(apm_pkg::IDX_MODE, 8'h00, 1'b0);
    mode_chk(apm_pkg::APM_NORMAL);
  endtask
  task automatic t_hold();
    int n;
    for (int v = 0; v < 2; v++) begin
      wake_hold <= 1'b1;
      samples_done <= 1'b1;
      wr_chk(apm_pkg::IDX_LPCFG, v[0] ? 8'h40 : 8'h00, 1'b0);
      wr_chk(apm_pkg::IDX_MODE, 8'h40, 1'b0);
      rd_chk(apm_pkg::IDX_FDATA, v[0] ? {24'h0, fifo_rd_data} : 32'h0,
             ~v[0]);
      repeat (20) @(negedge pclk);
      chk({26'h0, mode}, {26'h0, apm_pkg::APM_LPWAKE}, "held");
      @(posedge pclk);
      rd_chk(apm_pkg::IDX_STATUS, 32'h50, 1'b0);
      wake_hold <= 1'b0;
      n = 0;
      @(negedge pclk);
      while (mode !== apm_pkg::APM_LPSLEEP && n < 4) begin
        n++;
        @(negedge pclk);
      end
      chk({26'h0, mode}, {26'h0, apm_pkg::APM_LPSLEEP}, "slept");
      @(posedge pclk);
      wr_chk(apm_pkg::IDX_MODE, 8'h00, 1'b0);
      mode_chk(apm_pkg::APM_NORMAL);
    end
  endtask
  // one wake and sleep cycle, timed from the mode and power outputs
  task automatic t_meas(input logic [7:0] lp, input logic [3:0] c,
                        input int xw, input int xs, input int xf);
    int n, w, f, s, a;
    // the host's idle cycle after the write already runs in the wake phase
    n = 1;
    w = 1;
    f = 0;
    s = 0;
    a = 0;
    wr_chk(apm_pkg::IDX_LPCFG, lp, 1'b0);
    wr_chk(apm_pkg::IDX_MODE, {3'b010, c, 1'b0}, 1'b0);
    @(negedge pclk);
    while (mode === apm_pkg::APM_LPWAKE && n < 2000) begin
      if (pwr.sample_valid !== 1'b1) w++;
      if (pwr.fifo_store === 1'b1) f++;
      n++;
      @(negedge pclk);
    end
    while (mode === apm_pkg::APM_LPSLEEP && s < 9000) begin
      if (pwr.analog_on !== 1'b0) a++;
      s++;
      @(negedge pclk);
    end
    chk(w, xw, "settle cycles");
    chk(f, xf, "buffer stores");
    chk(s, xs, "sleep cycles");
    chk(a, 0, "analog in sleep");
    @(posedge pclk);
    wr_chk(apm_pkg::IDX_MODE, 8'h00, 1'b0);
    mode_chk(apm_pkg::APM_NORMAL);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(4 * 40000);
    n_errors++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    samples_done = 1'b0;
    wake_hold = 1'b0;
    fifo_rd_data = 8'h5c;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_entry();
    t_deep();
    t_susp();
    t_hold();
    samples_done <= 1'b1;
    // every sleep code, event-driven timing, first variant
    for (int c = 0; c < 16; c++) begin
      t_meas(8'h00, c[3:0], W1, mult[c] * UNIT, 0);
    end
    // equidistant timing ignores missing samples, second variant
    samples_done <= 1'b0;
    t_meas(8'h60, 4'h6, W2, 2 * UNIT, 1);
    wrap_up();
  end
endmodule
